// ===== verilog/pxb_defs.svh
// constants for the priority pin crossbar: offsets, field bits, resets
// assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address
`ifndef PXB_DEFS_SVH
`define PXB_DEFS_SVH
// sizes
`define PXB_ADDR_W 8
`define PXB_NUM_SLOTS 30
`define PXB_NUM_PINS 32
// register byte offsets
`define PXB_OFF_CFG_FIRST 8'h00
`define PXB_OFF_CFG_SECOND 8'h04
`define PXB_OFF_CFG_THIRD 8'h08
`define PXB_OFF_CFG_AUX 8'h0C
`define PXB_OFF_IN_MODE 8'h10
`define PXB_REGION_PORT 4'h2
`define PXB_REGION_LATCH 4'h3
// crossbar_config_first fields
`define PXB_F_SMBUS 0
`define PXB_F_SPI 1
`define PXB_F_SER_A 2
`define PXB_F_CNT_LO 3
`define PXB_F_CNT_HI 5
`define PXB_F_ECI 6
`define PXB_F_CMP_A 7
// crossbar_config_second fields
`define PXB_S_CMP_B 0
`define PXB_S_TMR_A 1
`define PXB_S_IRQ_A 2
`define PXB_S_TMR_B 3
`define PXB_S_IRQ_B 4
`define PXB_S_TMR_C 5
`define PXB_S_TMR_C_CAP 6
`define PXB_S_SYSTEM_CLOCK_OUTPUT 7
// crossbar_config_third fields
`define PXB_T_CNV_A 0
`define PXB_T_TMR_E_CAP 1
`define PXB_T_SER_B 2
`define PXB_T_TMR_E 3
`define PXB_T_GLOBAL 4
`define PXB_T_MEMIF 5
`define PXB_T_CNV_B 6
// aux register: memory interface multiplexed mode
`define PXB_A_MUXED 0
// reserved memory interface pins
`define PXB_PIN_WR 7
`define PXB_PIN_RD 6
`define PXB_PIN_ALE 5
// slots whose signal is an input to a peripheral
`define PXB_INPUT_SLOTS 30'h37F9_0202
// reset values
`define PXB_CFG_RST 8'h00
`define PXB_IN_MODE_RST 8'hFF
`define PXB_LATCH_RST 32'hFFFF_FFFF
// bus responses
`define PXB_RESP_OKAY 2'h0
`define PXB_RESP_SLVERR 2'h2
`endif

// ===== verilog/pxb_pkg.sv
// types shared by the priority pin crossbar
// assumes pxb_defs.svh for all numeric constants
package pxb_pkg;
  typedef logic [4:0] pxb_slot_t;
  typedef enum logic [1:0] {
    PXB_WR_IDLE = 2'b01,
    PXB_WR_RESP = 2'b10
  } pxb_wr_state_t;
endpackage

// ===== verilog/pxb_crossbar.sv
// priority crossbar mapping peripheral signals onto four 8-bit ports
// assumes one clock, pins synchronous to it, registers over AXI4-Lite
// Operation
// - serial a always lands on pins zero, one
// - disabled peripherals never reach a pin
// - serial peripherals get all signals together
// - unallocated pins act as general-purpose io
// - port data readable as bytes and bits
// - allocated pins driven by mapped peripheral
// - data writes never change allocated pins
// - port reads return sampled pin level
// - read-modify-write read returns latch contents
// - crossbar active only with global enable
// - global enable low keeps drivers off
// - input signal pins have drivers off
// - fixed allocation order of peripheral groups
// - pins granted sequentially from port zero
// - serial a highest, adc b start lowest
// - analog port-one pins are skipped
// - memory reserve skips strobe and latch pins
`include "pxb_defs.svh"
module pxb_crossbar (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [`PXB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [`PXB_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral side, one bit per signal slot
  input wire logic [`PXB_NUM_SLOTS-1:0] periph_out,
  input wire logic [`PXB_NUM_SLOTS-1:0] periph_oe,
  output logic [`PXB_NUM_SLOTS-1:0] periph_in,
  // port pins, bit 8*port+bit
  input wire logic [`PXB_NUM_PINS-1:0] pin_in,
  output logic [`PXB_NUM_PINS-1:0] pin_out,
  output logic [`PXB_NUM_PINS-1:0] pin_oe
);
  localparam int NSLOT = `PXB_NUM_SLOTS;
  localparam int NPIN = `PXB_NUM_PINS;
  localparam logic [NSLOT-1:0] INPUT_SLOTS = `PXB_INPUT_SLOTS;

  // configuration and port state
  logic [7:0] cfg_first_reg, cfg_second_reg, cfg_third_reg;
  logic [7:0] cfg_aux_reg, in_mode_reg;
  logic [NPIN-1:0] port_latch_reg;
  logic [NPIN-1:0] pin_out_reg, pin_oe_reg, pin_out_next, pin_oe_next;
  logic [NSLOT-1:0] periph_in_reg, periph_in_next;
  // allocation
  logic glob;
  logic [NSLOT-1:0] slot_req, slot_en, slot_granted;
  logic [NPIN-1:0] pin_avail, pin_alloc, pin_input, pin_level;
  logic [5:0] slot_rank [NSLOT];
  logic [5:0] pin_rank [NPIN];
  pxb_pkg::pxb_slot_t pin_slot [NPIN];
  // bus
  pxb_pkg::pxb_wr_state_t wr_state_reg;
  logic aw_held_reg, w_held_reg, wr_fire, rd_err;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rd_next, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic rvalid_reg;

  // count of set bits of v below index n
  function automatic logic [5:0] pxb_rank(input logic [31:0] v, input int n);
    logic [5:0] c;
    c = 6'h00;
    for (int j = 0; j < 32; j++) begin
      if (j < n && v[j]) begin
        c = c + 6'h01;
      end
    end
    return c;
  endfunction

  // true for every offset that holds a register
  function automatic logic pxb_mapped(input logic [7:0] a);
    logic m;
    m = a[7] || a[7:4] == `PXB_REGION_PORT || a[7:4] == `PXB_REGION_LATCH;
    case ({a[7:2], 2'b00})
      `PXB_OFF_CFG_FIRST, `PXB_OFF_CFG_SECOND, `PXB_OFF_CFG_THIRD,
      `PXB_OFF_CFG_AUX, `PXB_OFF_IN_MODE: m = 1'b1;
      default: m = m;
    endcase
    return m;
  endfunction

  // per-slot requests, slot order is grant priority
  always_comb begin
    slot_req = '0;
    slot_req[1:0] = {2{cfg_first_reg[`PXB_F_SER_A]}};
    slot_req[5:2] = {4{cfg_first_reg[`PXB_F_SPI]}};
    slot_req[7:6] = {2{cfg_first_reg[`PXB_F_SMBUS]}};
    slot_req[9:8] = {2{cfg_third_reg[`PXB_T_SER_B]}};
    for (int k = 0; k < 6; k++) begin
      slot_req[10+k] = cfg_first_reg[`PXB_F_CNT_HI:`PXB_F_CNT_LO] > 3'(k);
    end
    slot_req[16] = cfg_first_reg[`PXB_F_ECI];
    slot_req[17] = cfg_first_reg[`PXB_F_CMP_A];
    slot_req[18] = cfg_second_reg[`PXB_S_CMP_B];
    slot_req[19] = cfg_second_reg[`PXB_S_TMR_A];
    slot_req[20] = cfg_second_reg[`PXB_S_IRQ_A];
    slot_req[21] = cfg_second_reg[`PXB_S_TMR_B];
    slot_req[22] = cfg_second_reg[`PXB_S_IRQ_B];
    slot_req[23] = cfg_second_reg[`PXB_S_TMR_C];
    slot_req[24] = cfg_second_reg[`PXB_S_TMR_C_CAP];
    slot_req[25] = cfg_third_reg[`PXB_T_TMR_E];
    slot_req[26] = cfg_third_reg[`PXB_T_TMR_E_CAP];
    slot_req[27] = cfg_second_reg[`PXB_S_SYSTEM_CLOCK_OUTPUT];
    slot_req[28] = cfg_third_reg[`PXB_T_CNV_A];
    slot_req[29] = cfg_third_reg[`PXB_T_CNV_B];
  end

  // nothing is granted until the global enable is set
  assign glob = cfg_third_reg[`PXB_T_GLOBAL];
  assign slot_en = glob ? slot_req : '0;

  // pins open to allocation
  always_comb begin
    pin_avail = '1;
    pin_avail[15:8] = in_mode_reg;
    if (cfg_third_reg[`PXB_T_MEMIF]) begin
      pin_avail[`PXB_PIN_WR] = 1'b0;
      pin_avail[`PXB_PIN_RD] = 1'b0;
      if (cfg_aux_reg[`PXB_A_MUXED]) begin
        pin_avail[`PXB_PIN_ALE] = 1'b0;
      end
    end
  end

  // ranks: n-th enabled slot meets n-th free pin
  always_comb begin
    for (int s = 0; s < NSLOT; s++) begin
      slot_rank[s] = pxb_rank({2'b00, slot_en}, s);
    end
    for (int p = 0; p < NPIN; p++) begin
      pin_rank[p] = pxb_rank(pin_avail, p);
    end
  end

  // allocation; slots beyond the last free pin get nothing
  always_comb begin
    pin_alloc = '0;
    slot_granted = '0;
    periph_in_next = '0;
    for (int p = 0; p < NPIN; p++) begin
      pin_slot[p] = 5'h00;
      for (int s = 0; s < NSLOT; s++) begin
        if (pin_avail[p] && slot_en[s] && slot_rank[s] == pin_rank[p]) begin
          pin_alloc[p] = 1'b1;
          pin_slot[p] = 5'(s);
          slot_granted[s] = 1'b1;
          periph_in_next[s] = pin_in[p];
        end
      end
    end
  end

  // next pin drive
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      pin_input[p] = pin_alloc[p] && INPUT_SLOTS[pin_slot[p]];
      if (!glob) begin
        pin_out_next[p] = 1'b0;
        pin_oe_next[p] = 1'b0;
      end else if (pin_alloc[p]) begin
        pin_out_next[p] = periph_out[pin_slot[p]];
        pin_oe_next[p] = periph_oe[pin_slot[p]] && !pin_input[p];
      end else begin
        pin_out_next[p] = port_latch_reg[p];
        pin_oe_next[p] = !port_latch_reg[p];
      end
    end
  end

  // pin and peripheral outputs from flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
      periph_in_reg <= '0;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      periph_in_reg <= periph_in_next;
    end
  end
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign periph_in = periph_in_reg;

  // pin level seen by reads, analog pins read zero
  assign pin_level = {pin_in[31:16], pin_in[15:8] & in_mode_reg, pin_in[7:0]};

  // write channel handshakes
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = wr_state_reg == pxb_pkg::PXB_WR_RESP;
  assign s_axi_bresp = bresp_reg;
  assign wr_fire = wr_state_reg == pxb_pkg::PXB_WR_IDLE && aw_held_reg && w_held_reg;

  // write address, data and response sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bresp_reg <= `PXB_RESP_OKAY;
      wr_state_reg <= pxb_pkg::PXB_WR_IDLE;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      case (wr_state_reg)
        pxb_pkg::PXB_WR_IDLE: begin
          if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bresp_reg <= pxb_mapped(aw_addr_reg) ? `PXB_RESP_OKAY : `PXB_RESP_SLVERR;
            wr_state_reg <= pxb_pkg::PXB_WR_RESP;
          end
        end
        pxb_pkg::PXB_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= pxb_pkg::PXB_WR_IDLE;
          end
        end
        default: wr_state_reg <= pxb_pkg::PXB_WR_IDLE;
      endcase
    end
  end

  // configuration registers, byte lane zero only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_first_reg <= `PXB_CFG_RST;
      cfg_second_reg <= `PXB_CFG_RST;
      cfg_third_reg <= `PXB_CFG_RST;
      cfg_aux_reg <= `PXB_CFG_RST;
      in_mode_reg <= `PXB_IN_MODE_RST;
    end else if (wr_fire && w_strb_reg[0]) begin
      case ({aw_addr_reg[7:2], 2'b00})
        `PXB_OFF_CFG_FIRST: cfg_first_reg <= w_data_reg[7:0];
        `PXB_OFF_CFG_SECOND: cfg_second_reg <= w_data_reg[7:0];
        `PXB_OFF_CFG_THIRD: cfg_third_reg <= w_data_reg[7:0];
        `PXB_OFF_CFG_AUX: cfg_aux_reg <= w_data_reg[7:0];
        `PXB_OFF_IN_MODE: in_mode_reg <= w_data_reg[7:0];
        default: cfg_aux_reg <= cfg_aux_reg;
      endcase
    end
  end

  // port latch: byte and bit writes; allocated pins ignore it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_latch_reg <= `PXB_LATCH_RST;
    end else if (wr_fire && w_strb_reg[0]) begin
      if (aw_addr_reg[7]) begin
        port_latch_reg[aw_addr_reg[6:2]] <= w_data_reg[0];
      end else if (aw_addr_reg[7:4] == `PXB_REGION_PORT ||
                   aw_addr_reg[7:4] == `PXB_REGION_LATCH) begin
        port_latch_reg[{aw_addr_reg[3:2], 3'h0} +: 8] <= w_data_reg[7:0];
      end
    end
  end

  // read data selection
  always_comb begin
    rd_next = 32'h0000_0000;
    rd_err = !pxb_mapped(s_axi_araddr);
    if (s_axi_araddr[7]) begin
      rd_next[0] = pin_level[s_axi_araddr[6:2]];
    end else if (s_axi_araddr[7:4] == `PXB_REGION_PORT) begin
      rd_next[7:0] = pin_level[{s_axi_araddr[3:2], 3'h0} +: 8];
    end else if (s_axi_araddr[7:4] == `PXB_REGION_LATCH) begin
      rd_next[7:0] = port_latch_reg[{s_axi_araddr[3:2], 3'h0} +: 8];
    end else begin
      case ({s_axi_araddr[7:2], 2'b00})
        `PXB_OFF_CFG_FIRST: rd_next[7:0] = cfg_first_reg;
        `PXB_OFF_CFG_SECOND: rd_next[7:0] = cfg_second_reg;
        `PXB_OFF_CFG_THIRD: rd_next[7:0] = cfg_third_reg;
        `PXB_OFF_CFG_AUX: rd_next[7:0] = cfg_aux_reg;
        `PXB_OFF_IN_MODE: rd_next[7:0] = in_mode_reg;
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  // read channel
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `PXB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_next;
      rresp_reg <= rd_err ? `PXB_RESP_SLVERR : `PXB_RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // helpers watched by the checks below
  logic pin2_periph, rd_bit_sel;
  logic [7:0] rd_latch_sel;
  assign pin2_periph = periph_out[pin_slot[2]];
  assign rd_bit_sel = pin_level[s_axi_araddr[6:2]];
  assign rd_latch_sel = port_latch_reg[{s_axi_araddr[3:2], 3'h0} +: 8];

  // checks
  chk_serial_a_pins: assert property (@(posedge core_clk) disable iff (rst)
    glob && cfg_first_reg[`PXB_F_SER_A] |-> pin_alloc[0] && pin_alloc[1] &&
    pin_slot[0] == 5'h00 && pin_slot[1] == 5'h01)
    else $error("serial a not on pins zero and one");
  chk_enable_gates_pins: assert property (@(posedge core_clk) disable iff (rst)
    (slot_granted & ~slot_req) == '0 && (glob || pin_alloc == '0))
    else $error("pin granted to a disabled peripheral");
  chk_serial_together: assert property (@(posedge core_clk) disable iff (rst)
    (&slot_granted[1:0] || !(|slot_granted[1:0])) &&
    (&slot_granted[5:2] || !(|slot_granted[5:2])) &&
    (&slot_granted[7:6] || !(|slot_granted[7:6])) &&
    (&slot_granted[9:8] || !(|slot_granted[9:8])))
    else $error("serial peripheral partly allocated");
  chk_gpio_latch: assert property (@(posedge core_clk) disable iff (rst)
    glob && !pin_alloc[3] ##1 $stable(port_latch_reg) |->
    pin_out_reg[3] == port_latch_reg[3] && pin_oe_reg[3] == !port_latch_reg[3])
    else $error("free pin does not follow its latch bit");
  chk_periph_drive: assert property (@(posedge core_clk) disable iff (rst)
    glob && pin_alloc[2] |=> pin_out_reg[2] == $past(pin2_periph))
    else $error("allocated pin not driven by its peripheral");
  chk_pin_read: assert property (@(posedge core_clk) disable iff (rst)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7] |=>
    s_axi_rvalid && s_axi_rdata == {31'h0000_0000, $past(rd_bit_sel)})
    else $error("bit read does not return pin level");
  chk_rmw_latch: assert property (@(posedge core_clk) disable iff (rst)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] == `PXB_REGION_LATCH |=>
    s_axi_rvalid && s_axi_rdata[7:0] == $past(rd_latch_sel))
    else $error("latch read does not return stored data");
  chk_drivers_off: assert property (@(posedge core_clk) disable iff (rst)
    !glob |=> pin_oe_reg == '0)
    else $error("driver on while crossbar disabled");
  chk_input_undriven: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> (pin_oe_reg & $past(pin_input)) == '0)
    else $error("driver on a crossbar input pin");
  chk_skip_reserved: assert property (@(posedge core_clk) disable iff (rst)
    (pin_alloc[15:8] & ~in_mode_reg) == 8'h00 && !(cfg_third_reg[`PXB_T_MEMIF] &&
    (pin_alloc[`PXB_PIN_WR] || pin_alloc[`PXB_PIN_RD])))
    else $error("reserved or analog pin allocated");
  chk_fill_count: assert property (@(posedge core_clk) disable iff (rst)
    $countones(pin_alloc) == (($countones(slot_en) < $countones(pin_avail)) ?
    $countones(slot_en) : $countones(pin_avail)))
    else $error("allocated pin count wrong");
endmodule

// ===== dv/pxb_far_side.sv
// far side of the port pins: board drivers and weak pullups
// assumes pin levels are sampled in the core clock domain by the dut
module pxb_far_side (
  // dut pin drive
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  // board drive
  input wire logic [31:0] ext_drv,
  input wire logic [31:0] ext_val,
  // resolved level
  output logic [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // driven pins follow the dut, released ones the board or the pullup
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (~ext_drv | ext_val));
endmodule

// ===== dv/testbench.sv
// self-checking bench for the priority pin crossbar
// assumes pxb_defs.svh on the include path and pxb_far_side at the pins
`include "pxb_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [29:0] in_slots = `PXB_INPUT_SLOTS;
  logic core_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, cfg1, cfg2, cfg3, aux, inm;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] wdata, rdata, data, pin_out, pin_oe, pin_in, ext_drv, ext_val;
  logic [31:0] latch, exp_out, exp_oe, lvl, rd_lvl, seed;
  logic [29:0] pout, poe, periph_in, exp_pin_in;
  int pslot [32];
  int n_fail, num_checks;

  pxb_crossbar dut (
    .core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .periph_out(pout), .periph_oe(poe),
    .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
  );

  pxb_far_side far (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv), .ext_val(ext_val),
    .pin_in(pin_in)
  );

  // 25 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // hang guard
  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    close_out();
  end

  task automatic close_out();
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // axi4-lite write, address and data offered together
  // waits for the answer however long it takes; only the hang guard ends a stuck wait
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
  endtask

  // axi4-lite read, result in data and resp
  task automatic axi_rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic skip_pin(int q);
    return (q >= 8 && q < 16 && !inm[q - 8]) ||
      (cfg3[`PXB_T_MEMIF] && (q == 7 || q == 6 || (q == 5 && aux[`PXB_A_MUXED])));
  endfunction

  // expected allocation, pin drive and levels
  function automatic void calc_exp();
    logic [29:0] en;
    int p;
    int cnt;
    cnt = (cfg1[5:3] > 3'd6) ? 6 : int'(cfg1[5:3]);
    en = {cfg3[6], cfg3[0], cfg2[7], cfg3[1], cfg3[3], cfg2[6:1], cfg2[0], cfg1[7],
      cfg1[6], 6'h00, {2{cfg3[2]}}, {2{cfg1[0]}}, {4{cfg1[1]}}, {2{cfg1[2]}}};
    for (int i = 0; i < cnt; i++) en[10 + i] = 1'b1;
    p = 0;
    for (int q = 0; q < 32; q++) pslot[q] = -1;
    for (int s = 0; s < 30; s++) begin
      while (p < 32 && skip_pin(p)) p++;
      if (en[s] && cfg3[`PXB_T_GLOBAL] && p < 32) begin
        pslot[p] = s;
        p++;
      end
    end
    exp_pin_in = '0;
    for (int q = 0; q < 32; q++) begin
      if (pslot[q] >= 0) begin
        exp_out[q] = pout[pslot[q]];
        exp_oe[q] = poe[pslot[q]] & ~in_slots[pslot[q]];
      end else begin
        exp_out[q] = latch[q];
        exp_oe[q] = ~latch[q];
      end
      exp_oe[q] = exp_oe[q] & cfg3[`PXB_T_GLOBAL];
      lvl[q] = exp_oe[q] ? exp_out[q] : (~ext_drv[q] | ext_val[q]);
      if (pslot[q] >= 0) exp_pin_in[pslot[q]] = lvl[q];
    end
    rd_lvl = lvl & ~{16'h0000, ~inm, 8'h00};
  endfunction

  // let pins and routed inputs settle, then compare
  task automatic cmp_pins();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    calc_exp();
    chk(pin_oe, exp_oe);
    if (cfg3[`PXB_T_GLOBAL]) chk(pin_out, exp_out);
    chk({2'b00, periph_in}, {2'b00, exp_pin_in});
  endtask

  // reset, then fixed and random configurations
  initial begin
    int n;
    logic [31:0] r;
    logic [7:0] b;
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h3F & 6'h20;
    {awaddr, araddr, wdata} = '0;
    {cfg1, cfg2, cfg3, aux} = '0;
    inm = 8'hFF;
    latch = 32'hFFFF_FFFF;
    {pout, poe, ext_drv, ext_val} = '0;
    seed = 32'h0000_DE60;
    n_fail = 0;
    num_checks = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    cmp_pins();
    axi_rd(`PXB_OFF_IN_MODE);
    chk(data, 32'h0000_00FF);
    axi_rd(8'h30);
    chk(data, 32'h0000_00FF);
    axi_rd(8'h14);
    chk(32'(resp), 32'(`PXB_RESP_SLVERR));
    chk(data, 32'h0000_0000);
    axi_wr(8'h40, rnd());
    chk(32'(resp), 32'(`PXB_RESP_SLVERR));
    for (int it = 0; it < 14; it++) begin
      {cfg1, cfg2, cfg3, inm, aux} = {rnd(), 8'(rnd())} | 40'h00_0010_0000;
      if (it == 0) {cfg1, cfg2, cfg3, inm, aux} = 40'h04_0010_FF00;
      if (it == 1) {cfg1, cfg2, cfg3, inm, aux} = 40'hFF_FF7F_0001;
      if (it == 2) cfg3[`PXB_T_GLOBAL] = 1'b0;
      axi_wr(`PXB_OFF_CFG_FIRST, {24'h00_0000, cfg1});
      axi_wr(`PXB_OFF_CFG_SECOND, {24'h00_0000, cfg2});
      axi_wr(`PXB_OFF_CFG_AUX, {24'h00_0000, aux});
      axi_wr(`PXB_OFF_IN_MODE, {24'h00_0000, inm});
      axi_wr(`PXB_OFF_CFG_THIRD, {24'h00_0000, cfg3});
      for (int k = 0; k < 4; k++) begin
        b = 8'(rnd());
        axi_wr(8'h20 + 8'(it[0] ? 16 : 0) + 8'(4 * k), {24'h00_0000, b});
        latch[8 * k +: 8] = b;
      end
      r = rnd();
      n = int'(r[4:0]);
      latch[n] = r[8];
      axi_wr(8'h80 + 8'(4 * n), {31'h0000_0000, r[8]});
      // peripherals start after the crossbar is set up
      pout <= 30'(rnd());
      poe <= 30'(rnd());
      ext_drv <= rnd();
      ext_val <= rnd();
      cmp_pins();
      // third configuration register and latches read back what was written, port and bit reads give pin levels
      axi_rd(`PXB_OFF_CFG_THIRD);
      chk(data, {24'h00_0000, cfg3});
      chk(32'(resp), 32'(`PXB_RESP_OKAY));
      for (int k = 0; k < 4; k++) begin
        axi_rd(8'h20 + 8'(4 * k));
        chk(data, {24'h00_0000, rd_lvl[8 * k +: 8]});
        axi_rd(8'h30 + 8'(4 * k));
        chk(data, {24'h00_0000, latch[8 * k +: 8]});
      end
      axi_rd(8'h80 + 8'(4 * n));
      chk(data, {31'h0000_0000, rd_lvl[n]});
      axi_wr(8'h20, {24'h00_0000, ~latch[7:0]});
      latch[7:0] = ~latch[7:0];
      cmp_pins();
    end
    close_out();
  end
endmodule
